// >>> verilog/rcd_defs.svh
// Constants of the radar detection chain: register offsets, fields, presets.
// Assumes inclusion by bare name from the design module.
// Overview of operation
// - Power is real squared plus imaginary squared
// - Integrated power is new power plus 5/8 previous
// - Integrators preset to 128 before first sample
// - Feedback integration only in high-PRF search mode
// - Both noise estimates always computed for every cell
// - Window: max of guarded 16-cell sums, over 16
// - Window estimate produced for all 512 filters
// - Long average: mean of top delta-N filters
// - Ensemble estimate is max of window and long
// - Time estimate: 1/24 new plus 23/24 old
// - Thresholding uses time estimate three samples old
// - Time loop and delays initialised against false alarms
// - Processor selects noise estimate; every cell thresholded
// - Hit when power meets threshold, else miss
// - Lower multiplier cells 0-255, upper 256-511
// - Second threshold is 3/4 of detection threshold
// - Lower threshold crossings counted and reported
// - Threshold is squared multiplier times noise, greater-equal
// - Low counts per subband; detection count all cells
`ifndef RCD_DEFS_SVH
`define RCD_DEFS_SVH

// Register byte offsets
`define RCD_OFS_CTRL 8'h00
`define RCD_OFS_MULT 8'h04
`define RCD_OFS_STATUS 8'h08
`define RCD_OFS_COUNT_R 8'h0c
`define RCD_OFS_COUNT_1 8'h10
`define RCD_OFS_COUNT_2 8'h14

// Control fields
`define RCD_CTRL_MODE 0
`define RCD_CTRL_SEL 1
`define RCD_CTRL_START 2
`define RCD_CTRL_INIT 3

// Multiplier fields and fraction bits
`define RCD_MULT_LO_LSB 0
`define RCD_MULT_HI_LSB 8
`define RCD_MULT_FRAC 4

// Status fields
`define RCD_STAT_BUSY 0
`define RCD_STAT_DONE 1

// Presets and reset values
`define RCD_INTEG_PRESET 128
`define RCD_MULT_RESET 8'h10
`define RCD_WIN_LEN 16
`define RCD_WIN_NEAR 2
`define RCD_WIN_FAR 17

`endif

// >>> verilog/rcd_pkg.sv
// Types shared by the radar detection chain.
// Assumes nothing beyond the constants header.
`default_nettype none
package rcd_pkg;
    // One-hot sequencing states
    typedef enum logic [3:0]
    {
        ST_INIT = 4'b0001,
        ST_IDLE = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_DET = 4'b1000
    } rcd_state_e;
endpackage
`default_nettype wire

// >>> verilog/rcd_detect_chain.sv
// Power detection, feedback integration, two noise estimates and hit/miss.
// Assumes an AHB-Lite master and a bin source on hclk, one bin per beat.
//
// Added by the designer: the address map and the AHB-Lite register port.
`default_nettype none
`include "rcd_defs.svh"
module rcd_detect_chain
    import rcd_pkg::*;
#(
    parameter int NB = 512,
    parameter int IN_W = 16,
    parameter int MULT_W = 8,
    parameter int DELTA_N = 64
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic bin_valid,
    output logic bin_ready,
    input wire logic signed [IN_W-1:0] bin_re,
    input wire logic signed [IN_W-1:0] bin_im,
    output logic hit_valid,
    output logic [8:0] hit_index,
    output logic hit_flag,
    output logic low_hit_flag
);
    // Integrated power width, extended math width, window sum, threshold
    localparam int PW = 2 * IN_W + 3;
    localparam int EW = PW + 5;
    localparam int SW = PW + 4;
    localparam int TW = PW + 2 * MULT_W;
    localparam int LW = PW + 10;

    // Refuse settings the index and register widths cannot carry
    if (NB != 512 || DELTA_N < 1 || DELTA_N > NB || MULT_W > 8 || IN_W > 30)
    begin : g_bad
        $error("rcd_detect_chain: unsupported parameter values");
    end

    // Per-filter memories
    logic [PW-1:0] integ_mem [NB]; // Integrated power
    logic [PW-1:0] tavg_mem [NB]; // Time estimate, latest
    logic [PW-1:0] tavg_h1 [NB]; // One sample older
    logic [PW-1:0] tavg_h2 [NB]; // Two samples older
    logic [PW-1:0] tad_mem [NB]; // Estimate three samples old

    rcd_state_e state; // Sequencer state
    logic [8:0] idx; // Cell index
    logic ctrl_mode; // High-PRF search mode
    logic ctrl_sel; // 1 selects time estimate
    logic [MULT_W-1:0] mult_lo; // Lower band multiplier
    logic [MULT_W-1:0] mult_hi; // Upper band multiplier
    logic start_req; // Frame start pulse
    logic init_req; // Reinitialise pulse
    logic done; // Frame complete flag
    logic [9:0] count_r; // Detection hits
    logic [8:0] count_1; // Low hits, lower band
    logic [8:0] count_2; // Low hits, upper band
    logic [LW-1:0] long_sum; // Long average accumulator
    logic ap_valid; // Data phase pending
    logic ap_write; // Pending is a write
    logic [7:0] ap_addr; // Pending offset
    logic accept; // Bin taken this cycle
    logic [2*IN_W-1:0] sq_re; // Real square
    logic [2*IN_W-1:0] sq_im; // Imaginary square
    logic [PW-1:0] pwr; // Bin power
    logic [PW-1:0] integ_new; // New integrated power
    logic [PW-1:0] tavg_new; // New time estimate
    logic [SW-1:0] win_lo; // Lower window sum
    logic [SW-1:0] win_hi; // Upper window sum
    logic [PW-1:0] win_est; // Window estimate
    logic [PW-1:0] long_est; // Long estimate
    logic [PW-1:0] noise; // Selected estimate
    logic [MULT_W-1:0] mult; // Multiplier for this cell
    logic [TW-1:0] thr; // Detection threshold
    logic [TW-1:0] thr_low; // Lower threshold
    logic hit_now; // Detection hit
    logic low_now; // Lower threshold hit

    // Sum of sixteen guarded neighbours on one side; outside cells add zero
    function automatic logic [SW-1:0] win_sum(input int c, input logic up);
        logic [SW-1:0] s;
        int j;
        int p;
        s = '0;
        for (j = `RCD_WIN_NEAR; j <= `RCD_WIN_FAR; j++)
        begin
            p = up ? c + j : c - j;
            if (p >= 0 && p < NB)
            begin
                s = s + SW'(integ_mem[p]);
            end
        end
        return s;
    endfunction

    // Bus is always ready and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign bin_ready = (state == ST_LOAD);
    assign accept = bin_valid && bin_ready;

    // Power of the incoming bin
    always_comb
    begin
        sq_re = bin_re * bin_re;
        sq_im = bin_im * bin_im;
        pwr = PW'(sq_re) + PW'(sq_im);
    end

    // Feedback integration and time estimate, widened so nothing overflows
    always_comb
    begin
        integ_new = pwr;
        if (ctrl_mode)
        begin
            integ_new = pwr + PW'((EW'(integ_mem[idx]) * EW'(5)) >> 3);
        end
        tavg_new = PW'((EW'(integ_new) + EW'(tavg_mem[idx]) * EW'(23)) / EW'(24));
    end

    // Noise estimates and thresholds for the cell under detection
    always_comb
    begin
        win_lo = win_sum(int'(idx), 1'b0);
        win_hi = win_sum(int'(idx), 1'b1);
        win_est = PW'((win_lo > win_hi ? win_lo : win_hi) / SW'(`RCD_WIN_LEN));
        long_est = PW'(long_sum / LW'(DELTA_N));
        noise = (win_est > long_est) ? win_est : long_est;
        if (ctrl_sel)
        begin
            noise = tad_mem[idx];
        end
        mult = (idx < 9'(NB / 2)) ? mult_lo : mult_hi;
        thr = (TW'(mult) * TW'(mult) * TW'(noise)) >> (2 * `RCD_MULT_FRAC);
        thr_low = thr - (thr >> 2);
        hit_now = TW'(integ_mem[idx]) >= thr;
        low_now = TW'(integ_mem[idx]) >= thr_low;
    end

    // Sequencer: init sweep, idle, load a frame, detect every cell
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_INIT;
            idx <= 9'h000;
        end
        else
        begin
            case (state)
                ST_INIT:
                begin
                    idx <= idx + 9'h001;
                    if (idx == 9'(NB - 1))
                    begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE:
                begin
                    idx <= 9'h000;
                    if (init_req)
                    begin
                        state <= ST_INIT;
                    end
                    else if (start_req)
                    begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    if (accept)
                    begin
                        idx <= idx + 9'h001;
                        if (idx == 9'(NB - 1))
                        begin
                            state <= ST_DET;
                        end
                    end
                end
                ST_DET:
                begin
                    idx <= idx + 9'h001;
                    if (idx == 9'(NB - 1))
                    begin
                        state <= ST_IDLE;
                    end
                end
                default:
                begin
                    state <= ST_INIT;
                    idx <= 9'h000;
                end
            endcase
        end
    end

    // Per-filter memories: preset during init, updated per loaded bin
    always_ff @(posedge hclk)
    begin
        if (state == ST_INIT)
        begin
            integ_mem[idx] <= PW'(`RCD_INTEG_PRESET);
            tavg_mem[idx] <= '1;
            tavg_h1[idx] <= '1;
            tavg_h2[idx] <= '1;
            tad_mem[idx] <= '1;
        end
        else if (accept)
        begin
            integ_mem[idx] <= integ_new;
            tavg_mem[idx] <= tavg_new;
            tavg_h1[idx] <= tavg_mem[idx];
            tavg_h2[idx] <= tavg_h1[idx];
            tad_mem[idx] <= tavg_h2[idx];
        end
    end

    // Long average accumulates the top filters of the frame
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            long_sum <= '0;
        end
        else if (state == ST_IDLE && start_req)
        begin
            long_sum <= '0;
        end
        else if (accept && idx >= 9'(NB - DELTA_N))
        begin
            long_sum <= long_sum + LW'(integ_new);
        end
    end

    // Hit outputs and counters during detection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hit_valid <= 1'b0;
            hit_index <= 9'h000;
            hit_flag <= 1'b0;
            low_hit_flag <= 1'b0;
            count_r <= 10'h000;
            count_1 <= 9'h000;
            count_2 <= 9'h000;
        end
        else
        begin
            hit_valid <= (state == ST_DET);
            hit_index <= idx;
            hit_flag <= (state == ST_DET) && hit_now;
            low_hit_flag <= (state == ST_DET) && low_now;
            if (state == ST_IDLE && start_req)
            begin
                count_r <= 10'h000;
                count_1 <= 9'h000;
                count_2 <= 9'h000;
            end
            else if (state == ST_DET)
            begin
                count_r <= count_r + 10'(hit_now);
                if (idx < 9'(NB / 2))
                begin
                    count_1 <= count_1 + 9'(low_now);
                end
                else
                begin
                    count_2 <= count_2 + 9'(low_now);
                end
            end
        end
    end

    // Done flag: set at the last cell, cleared by a new start
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            done <= 1'b0;
        end
        else if (state == ST_DET && idx == 9'(NB - 1))
        begin
            done <= 1'b1;
        end
        else if (state == ST_IDLE && start_req)
        begin
            done <= 1'b0;
        end
    end

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end
        else if (hready)
        begin
            ap_valid <= hsel && htrans[1];
            ap_write <= hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    // Register writes in the data phase; start and init are pulses
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_mode <= 1'b1;
            ctrl_sel <= 1'b0;
            mult_lo <= MULT_W'(`RCD_MULT_RESET);
            mult_hi <= MULT_W'(`RCD_MULT_RESET);
            start_req <= 1'b0;
            init_req <= 1'b0;
        end
        else
        begin
            start_req <= 1'b0;
            init_req <= 1'b0;
            if (ap_valid && ap_write && ap_addr == `RCD_OFS_CTRL)
            begin
                ctrl_mode <= hwdata[`RCD_CTRL_MODE];
                ctrl_sel <= hwdata[`RCD_CTRL_SEL];
                start_req <= hwdata[`RCD_CTRL_START];
                init_req <= hwdata[`RCD_CTRL_INIT];
            end
            if (ap_valid && ap_write && ap_addr == `RCD_OFS_MULT)
            begin
                mult_lo <= hwdata[`RCD_MULT_LO_LSB +: MULT_W];
                mult_hi <= hwdata[`RCD_MULT_HI_LSB +: MULT_W];
            end
        end
    end

    // Read data prepared at the address phase, unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                `RCD_OFS_CTRL: hrdata <= 32'({ctrl_sel, ctrl_mode});
                `RCD_OFS_MULT: hrdata <= {16'h0000, 8'(mult_hi), 8'(mult_lo)};
                `RCD_OFS_STATUS: hrdata <= 32'({done, state != ST_IDLE});
                `RCD_OFS_COUNT_R: hrdata <= 32'(count_r);
                `RCD_OFS_COUNT_1: hrdata <= 32'(count_1);
                `RCD_OFS_COUNT_2: hrdata <= 32'(count_2);
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> dv/rcd_chain_checker.sv
// Port checker of the detection chain.
// Assumes binding onto rcd_detect_chain, one clock, async reset.
`default_nettype none
module rcd_chain_checker
#(
    parameter int NB = 512
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic bin_valid,
    input wire logic bin_ready,
    input wire logic hit_valid,
    input wire logic [8:0] hit_index,
    input wire logic hit_flag,
    input wire logic low_hit_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_q; // Cells reported so far in this sweep
    int acc_q; // Bins accepted so far in this frame
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Counts sweep length and accepted bins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_q <= 0;
            acc_q <= 0;
        end
        else
        begin
            run_q <= hit_valid ? run_q + 1 : 0;
            acc_q <= hit_valid ? 0 : acc_q + int'(bin_valid && bin_ready);
        end
    end
    a_bus_okay:
        assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    a_first_cell:
        assert property ($rose(hit_valid) |-> hit_index == 9'h0)
        else $error("sweep does not start at cell 0");
    a_cell_step:
        assert property (hit_valid && $past(hit_valid) |-> hit_index == $past(hit_index) + 9'h1)
        else $error("cell index not consecutive");
    a_sweep_len:
        assert property ($fell(hit_valid) |-> run_q == NB) else $error("sweep length wrong");
    a_sweep_max:
        assert property (hit_valid |-> run_q < NB) else $error("sweep too long");
    a_low_implied:
        assert property (hit_valid && hit_flag |-> low_hit_flag)
        else $error("hit without lower threshold hit");
    a_no_overlap:
        assert property (bin_ready |-> !hit_valid) else $error("results during loading");
    a_frame_bins:
        assert property ($fell(bin_ready) |-> acc_q == NB) else $error("frame bin count wrong");
    a_sweep_follows:
        assert property ($fell(bin_ready) |-> ##[1:3] hit_valid) else $error("no sweep after frame");
endmodule
bind rcd_detect_chain rcd_chain_checker #(.NB(NB)) u_chk
(
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .bin_valid(bin_valid), .bin_ready(bin_ready), .hit_valid(hit_valid),
    .hit_index(hit_index), .hit_flag(hit_flag), .low_hit_flag(low_hit_flag)
);
`default_nettype wire

// >>> dv/rcd_bin_source.sv
// Spectrum bin source standing in for the upstream transform.
// Assumes the bench fills re_a and im_a, then calls send_frame.
`default_nettype none
module rcd_bin_source
(
    input wire logic hclk,
    input wire logic bin_ready,
    output logic bin_valid,
    output logic signed [15:0] bin_re,
    output logic signed [15:0] bin_im
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [15:0] re_a [512]; // Real parts of one frame
    logic signed [15:0] im_a [512]; // Imaginary parts of one frame
    initial
    begin
        bin_valid = 1'b0;
        bin_re = 16'h0;
        bin_im = 16'h0;
    end
    // Released lines show the inverse of the last value
    task automatic idle_beat();
        bin_valid <= 1'b0;
        bin_re <= ~bin_re;
        bin_im <= ~bin_im;
        @(posedge hclk);
    endtask
    // Bins 0..511 in order, each held until taken, stalls every gap-th bin
    task automatic send_frame(input int gap);
        for (int i = 0; i < 512; i++)
        begin
            if (i % gap == 3)
            begin
                idle_beat();
                idle_beat();
            end
            bin_valid <= 1'b1;
            bin_re <= re_a[i];
            bin_im <= im_a[i];
            forever
            begin
                @(negedge hclk);
                if (bin_ready === 1'b1)
                    break;
            end
            @(posedge hclk);
        end
        idle_beat();
    endtask
endmodule
`default_nettype wire

// >>> dv/radar_cfar_detection_chain_tb.sv
// Self-checking bench of the detection chain over AHB-Lite and the bin stream.
// Assumes design, checker and bin source are compiled first.
`default_nettype none
module radar_cfar_detection_chain_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DN = 64; // Filters in the long average
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bin_valid, bin_ready;
    logic hit_valid, hit_flag, low_hit_flag;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [8:0] hit_index;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic signed [15:0] bin_re, bin_im;
    logic [31:0] exp_q [$]; // Expected cell results, oldest first
    longint pw [512]; // Power of each cell
    int err_total, n_compared, c_r, c_1, c_2;
    rcd_detect_chain #(.DELTA_N(DN)) dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bin_valid(bin_valid),
        .bin_ready(bin_ready), .bin_re(bin_re), .bin_im(bin_im), .hit_valid(hit_valid),
        .hit_index(hit_index), .hit_flag(hit_flag), .low_hit_flag(low_hit_flag)
    );
    rcd_bin_source src
    (
        .hclk(hclk), .bin_ready(bin_ready), .bin_valid(bin_valid),
        .bin_re(bin_re), .bin_im(bin_im)
    );
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One single AHB-Lite transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(rd & m, e);
    endtask
    // Notes one cell result and tallies the counts
    task automatic note(input int k, input bit h, input bit l);
        exp_q.push_back({21'h0, 9'(k), h, l});
        c_r += h;
        if (k < 256)
            c_1 += l;
        else
            c_2 += l;
    endtask
    // Random small bins with a strong tone every 37 cells
    task automatic make_frame();
        for (int i = 0; i < 512; i++)
        begin
            seed = lfsr(seed);
            src.re_a[i] = (i % 37 == 5) ? 16'sd2000 : {{9{seed[6]}}, seed[6:0]};
            src.im_a[i] = {{9{seed[14]}}, seed[14:8]};
            pw[i] = longint'(src.re_a[i]) * src.re_a[i] + longint'(src.im_a[i]) * src.im_a[i];
        end
    endtask
    // Ensemble estimate thresholding of a frame without feedback
    task automatic expect_ens(input int mlo, input int mhi);
        longint sl, sr, long_est, nz, thr;
        long_est = 0;
        for (int j = 512 - DN; j < 512; j++)
            long_est += pw[j];
        long_est = long_est / DN;
        for (int k = 0; k < 512; k++)
        begin
            sl = 0;
            sr = 0;
            for (int j = 2; j < 18; j++)
            begin
                if (k - j >= 0)
                    sl += pw[k - j];
                if (k + j < 512)
                    sr += pw[k + j];
            end
            nz = ((sl > sr) ? sl : sr) / 16;
            if (long_est > nz)
                nz = long_est;
            thr = ((k < 256 ? mlo * mlo : mhi * mhi) * nz) >> 8;
            note(k, pw[k] >= thr, pw[k] >= thr - (thr >> 2));
        end
    endtask
    task automatic run_frame(input logic [31:0] ctrl, input int gap);
        bus(1'b1, 8'h00, ctrl | 32'h4);
        src.send_frame(gap);
        do bus(1'b0, 8'h08, 32'h0); while (rd[1] !== 1'b1);
        cmp(32'(exp_q.size()), 32'h0);
        rchk(8'h0c, 32'hffffffff, 32'(c_r));
        rchk(8'h10, 32'hffffffff, 32'(c_1));
        rchk(8'h14, 32'hffffffff, 32'(c_2));
    endtask
    // The first read can still see the state before a just-written init
    task automatic wait_idle();
        bus(1'b0, 8'h08, 32'h0);
        do bus(1'b0, 8'h08, 32'h0); while (rd[0] !== 1'b0);
    endtask
    // Compares each reported cell with the oldest note
    always @(negedge hclk)
    begin
        if (hit_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp(32'hffffffff, 32'h0);
            else
                cmp({21'h0, hit_index, hit_flag, low_hit_flag}, exp_q.pop_front());
        end
    end
    initial
    begin
        #200us;
        err_total++;
        stop_test();
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        seed = 32'h9436;
        err_total = 0;
        n_compared = 0;
        c_r = 0;
        c_1 = 0;
        c_2 = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(8'h00, 32'hf, 32'h1);
        rchk(8'h04, 32'hff, 32'h10);
        rchk(8'h1c, 32'hffffffff, 32'h0);
        wait_idle();
        bus(1'b1, 8'h04, 32'h1820);
        rchk(8'h04, 32'hffff, 32'h1820);
        make_frame();
        expect_ens(32, 24);
        run_frame(32'h0, 5);
        bus(1'b1, 8'h00, 32'h8);
        wait_idle();
        make_frame();
        c_r = 0;
        c_1 = 0;
        c_2 = 0;
        for (int k = 0; k < 512; k++)
            note(k, 1'b0, 1'b0);
        run_frame(32'h3, 7);
        stop_test();
    end
endmodule
`default_nettype wire
